/* File: verilog/lnb_control_status_regs.sv */
// Control and status byte registers behind a two-wire serial slave.
// Assumes SCL/SDA/fault inputs are asynchronous pins; SDA and IRQ are
// open-drain with external pull-ups resolved outside.
module lnb_control_status_regs
  import lnb_regs_pkg::*;
#(
  parameter int OC_CYCLES = OC_DETECT_CYC,  // Overcurrent detection count
  parameter int OC_W      = 16              // Width of detection counter
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_i,            // Serial clock pin
  input  wire logic       sda_i,            // Serial data pin level
  output logic            sda_o,            // Always low when enabled
  output logic            sda_oe_n,         // Low while pulling SDA low
  output logic            irq_o,            // Always low when enabled
  output logic            irq_oe_n,         // Low while requesting
  input  wire logic [1:0] addr_sel,         // Low address bits strap
  input  wire logic       thermal_cond,     // Overtemperature detected
  input  wire logic       overcur_cond,     // Output in current limit
  input  wire logic       undervolt_cond,   // Input below lockout
  input  wire logic       below_85_cond,    // Output below 85% of target
  input  wire logic       within_90_cond,   // Output within 90% of target
  output logic [2:0]      level_trim,       // 333 mV trim steps
  output logic            range_select,
  output logic            overcurrent_timeout_enable,
  output logic            output_enable,    // Regulated output on
  output logic            current_limit_select,
  output logic            tone_gate
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [8:0] pins_s;                       // Synchronised pin levels
  pin_sync #(
    .WIDTH   (9),
    .RST_VAL (32'h0000_0003)                // Bus lines idle high
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({addr_sel, within_90_cond, below_85_cond, undervolt_cond,
              overcur_cond, thermal_cond, sda_i, scl_i}),
    .q      (pins_s)
  );

  logic       scl_s, sda_s, therm_s, oc_s, uv_s, lo85_s, in90_s;
  logic [1:0] addr_s;
  assign scl_s   = pins_s[0];
  assign sda_s   = pins_s[1];
  assign therm_s = pins_s[2];
  assign oc_s    = pins_s[3];
  assign uv_s    = pins_s[4];
  assign lo85_s  = pins_s[5];
  assign in90_s  = pins_s[6];
  assign addr_s  = pins_s[8:7];

  // ------------------------------------------------------------------
  // Bus line edges and conditions
  // ------------------------------------------------------------------
  logic scl_q_r, sda_q_r;                   // Previous synchronised levels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s & ~scl_q_r;
  assign scl_fall  = ~scl_s & scl_q_r;
  assign bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign bus_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // ------------------------------------------------------------------
  // Slave state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_WR_DATA, S_WR_ACK, S_RD_DATA, S_RD_ACK,
    S_WAIT_STOP
  } slave_state_e;

  slave_state_e state_r;
  logic [3:0]   bit_cnt_r;                  // Rising SCL edges in a byte
  logic [7:0]   rx_r;                       // Received shift register
  logic [7:0]   tx_r;                       // Transmit shift register
  logic         rw_r;                       // Read requested
  logic         drive_low_r;                // Pull SDA low
  logic         master_ack_r;               // Master wants another byte
  logic         wr_done_r;                  // Control byte taken this frame
  logic [7:0]   ctrl_r;                     // Output control register
  logic [7:0]   status_byte;
  logic         addr_hit;

  assign addr_hit = (rx_r[7:1] == {ADDR_PREFIX, addr_s});

  // Status read acknowledge: the ninth rising clock of a read byte
  logic rd_resample;
  assign rd_resample = (state_r == S_RD_ACK) & scl_rise;  // [R10] [R12] [R20]

  // Address acknowledged for a read
  logic rd_addressed;
  assign rd_addressed = (state_r == S_ADDR) & scl_fall & (bit_cnt_r == 4'h8)
                      & addr_hit & rx_r[0];

  // ------------------------------------------------------------------
  // Byte framing and state sequencing
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= S_IDLE;
      bit_cnt_r <= 4'h0;
      rw_r      <= 1'b0;
    end else if (bus_start) begin
      state_r   <= S_ADDR;                  // Start restarts any transfer
      bit_cnt_r <= 4'h0;
    end else if (bus_stop) begin
      state_r   <= S_IDLE;
    end else if (scl_rise) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (scl_fall) begin
      unique case (state_r)
        S_ADDR: begin
          if (bit_cnt_r == 4'h8) begin
            // Foreign address: stay silent until next start
            state_r <= addr_hit ? S_ADDR_ACK : S_IDLE;
            rw_r    <= rx_r[0];
          end
        end
        S_ADDR_ACK: begin
          state_r   <= rw_r ? S_RD_DATA : S_WR_DATA;
          bit_cnt_r <= 4'h0;
        end
        S_WR_DATA: begin
          if (bit_cnt_r == 4'h8) begin
            state_r <= S_WR_ACK;
          end
        end
        S_WR_ACK: begin
          state_r <= S_WAIT_STOP;           // [R25]
        end
        S_RD_DATA: begin
          if (bit_cnt_r == 4'h8) begin
            state_r <= S_RD_ACK;
          end
        end
        S_RD_ACK: begin
          // Master ack asks for another status byte
          state_r   <= master_ack_r ? S_RD_DATA : S_WAIT_STOP;
          bit_cnt_r <= 4'h0;
        end
        S_IDLE, S_WAIT_STOP: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Receive shifter and master acknowledge sample
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_r         <= 8'h00;
      master_ack_r <= 1'b0;
    end else if (scl_rise) begin
      rx_r <= {rx_r[6:0], sda_s};
      if (state_r == S_RD_ACK) begin
        master_ack_r <= ~sda_s;
      end
    end
  end

  // ------------------------------------------------------------------
  // SDA drive: address/data acknowledge and read data
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_low_r <= 1'b0;
      tx_r        <= 8'h00;
    end else if (bus_start || bus_stop) begin
      drive_low_r <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_r)
        S_ADDR: begin
          drive_low_r <= (bit_cnt_r == 4'h8) & addr_hit;
        end
        S_ADDR_ACK: begin
          // Snapshot of status taken as the first byte starts
          tx_r        <= status_byte;
          drive_low_r <= rw_r & ~status_byte[7];
        end
        S_WR_DATA: begin
          drive_low_r <= (bit_cnt_r == 4'h8);
        end
        S_RD_DATA: begin
          if (bit_cnt_r == 4'h8) begin
            drive_low_r <= 1'b0;            // Free the line for master ack
          end else begin
            drive_low_r <= ~tx_r[6];
            tx_r        <= {tx_r[6:0], 1'b0};
          end
        end
        S_RD_ACK: begin
          // Flags were updated at the ninth rise, so this byte is fresh
          tx_r        <= status_byte;
          drive_low_r <= master_ack_r & ~status_byte[7];
        end
        S_IDLE, S_WR_ACK, S_WAIT_STOP: begin
          drive_low_r <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Control register write
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r    <= CTL_RESET;               // [R23]
      wr_done_r <= 1'b0;
    end else if (bus_start || bus_stop) begin
      wr_done_r <= 1'b0;
    end else if (scl_fall && state_r == S_WR_DATA && bit_cnt_r == 4'h8) begin
      ctrl_r    <= rx_r;                    // Only one byte per frame [R25]
      wr_done_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Overcurrent disable timer
  // ------------------------------------------------------------------
  logic [OC_W-1:0] oc_cnt_r;
  logic            out_on_r;                // Regulated output running
  logic            oc_trip;
  assign oc_trip = oc_s & ctrl_r[CTL_OCT] & out_on_r
                 & (oc_cnt_r == OC_W'(OC_CYCLES - 1));  // [R11] [R13]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oc_cnt_r <= '0;
    end else if (oc_s && ctrl_r[CTL_OCT] && out_on_r && !oc_trip) begin
      oc_cnt_r <= oc_cnt_r + OC_W'(1);      // [R5]
    end else begin
      oc_cnt_r <= '0;                       // Timer off: limit indefinitely
    end
  end

  // ------------------------------------------------------------------
  // Fault events: rising conditions and timer trip
  // ------------------------------------------------------------------
  logic therm_q_r, uv_q_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      therm_q_r <= 1'b0;
      uv_q_r    <= 1'b0;
    end else begin
      therm_q_r <= therm_s;
      uv_q_r    <= uv_s;
    end
  end

  logic [2:0] fault_set, fault_cond, fault_flag;
  assign fault_set  = {uv_s & ~uv_q_r, oc_trip, therm_s & ~therm_q_r};
  assign fault_cond = {uv_s, oc_s, therm_s};

  logic any_fault;
  assign any_fault = |fault_set;

  // ------------------------------------------------------------------
  // Sticky fault flags: thermal, overcurrent, undervoltage
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_fault
      fault_latch #(
        .RST_VAL     ((gi == 2) ? UV_RESET : 1'b0),
        .KEEP_ACTIVE ((gi == 1) ? 1'b0 : 1'b1)  // Overcurrent always clears
      ) u_flag (
        .clk      (clk),
        .arst_n   (arst_n),
        .set_evt  (fault_set[gi]),          // [R9] [R11] [R19]
        .resample (rd_resample),            // [R7]
        .cond     (fault_cond[gi]),
        .flag     (fault_flag[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Output on/off and output-off flag
  // ------------------------------------------------------------------
  logic out_off_r;
  logic wr_end;
  assign wr_end = bus_stop & wr_done_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_on_r  <= 1'b0;
      out_off_r <= OUT_OFF_RESET;           // [R16]
    end else if (any_fault) begin
      out_on_r  <= 1'b0;                    // Fault wins over a write [R9] [R19]
      out_off_r <= 1'b1;                    // [R16]
    end else if (wr_end) begin
      out_on_r  <= ctrl_r[CTL_ENABLE];      // [R1]
      out_off_r <= ~ctrl_r[CTL_ENABLE];     // [R18]
    end
  end

  // ------------------------------------------------------------------
  // Power-low flag with hysteresis
  // ------------------------------------------------------------------
  logic power_low_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      power_low_r <= 1'b0;
    end else if (!out_on_r) begin
      power_low_r <= 1'b0;                  // Only judged while enabled
    end else if (lo85_s) begin
      power_low_r <= 1'b1;                  // [R15]
    end else if (in90_s) begin
      power_low_r <= 1'b0;                  // [R15]
    end
  end

  // Reserved positions fixed at zero; all zero when healthy [R8] [R14] [R26]
  always_comb begin
    status_byte               = 8'h00;
    status_byte[ST_THERMAL]   = fault_flag[0];
    status_byte[ST_OVERCUR]   = fault_flag[1];
    status_byte[ST_POWER_LOW] = power_low_r;
    status_byte[ST_OUT_OFF]   = out_off_r;
    status_byte[ST_UNDERVOLT] = fault_flag[2];
  end

  // ------------------------------------------------------------------
  // Interrupt request: faults and power-up only
  // ------------------------------------------------------------------
  logic irq_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b1;                        // Power-up request [R22]
    end else if (any_fault) begin
      irq_r <= 1'b1;                        // Output-off changes excluded [R17]
    end else if (rd_addressed) begin
      irq_r <= 1'b0;                        // [R22]
    end
  end

  // ------------------------------------------------------------------
  // Pin and control outputs, all from flops
  // ------------------------------------------------------------------
  logic pin_low_r;                          // Open-drain data value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_low_r <= 1'b0;
    end else begin
      pin_low_r <= 1'b0;
    end
  end

  assign sda_o                      = pin_low_r;
  assign irq_o                      = pin_low_r;
  assign sda_oe_n                   = ~drive_low_r;
  assign irq_oe_n                   = ~irq_r;
  assign level_trim                 = ctrl_r[CTL_TRIM_LO +: 3];  // [R24]
  assign range_select               = ctrl_r[CTL_RANGE];         // [R4]
  assign overcurrent_timeout_enable = ctrl_r[CTL_OCT];           // [R5]
  assign output_enable              = out_on_r;                  // [R1]
  assign current_limit_select       = ctrl_r[CTL_CLIM];          // [R2]
  assign tone_gate                  = ctrl_r[CTL_TONE];          // [R3]

endmodule // lnb_control_status_regs

/* File: include/lnb_regs_pkg.sv */
// Constants for the regulator's control and status byte registers.
// Assumes a 125 MHz system clock and an I2C master on the far side.
// Function
// R1: Control bit 5 switches the output on.
// R2: Control bit 6 picks 500/700 mA limit.
// R3: Control bit 7 gates the tone on.
// R4: Control bit 3 picks low/high range.
// R5: Control bit 4 enables overcurrent disable timer.
// R6: Fault flags stay set until status read.
// R7: Only power-low/output-off clear without read.
// R8: Fault-free operation reads status as zero.
// R9: Overtemperature sets bit 0, kills output.
// R10: Ninth read clock resamples overtemperature condition.
// R11: Timed-out overcurrent kills output, sets bit 1.
// R12: Ninth read clock always clears overcurrent.
// R13: Timer disabled: never set overcurrent flag.
// R14: Status bits 2, 3, 6 reserved.
// R15: Power-low flag with 85%/90% hysteresis.
// R16: Output-off flag set at power-on, faults.
// R17: Output-off flag alone raises no interrupt.
// R18: Write leaving output enabled clears output-off.
// R19: Undervoltage sets bit 7, kills output.
// R20: Ninth read clock resamples undervoltage condition.
// R21: Master re-reads status until fault clears.
// R22: Interrupt on faults, power-up; read address clears.
// R23: Control register powers up all zero.
// R24: Control bits 0-2 trim level by 333 mV.
// R25: One control byte per addressed write.
// R26: Reserved status bits read as zero.
package lnb_regs_pkg;

  // ------------------------------------------------------------------
  // Bus address and field layout
  // ------------------------------------------------------------------
  localparam logic [4:0] ADDR_PREFIX   = 5'h02;   // Fixed upper address bits
  localparam int         CTL_TRIM_LO   = 0;       // Level trim field, 3 bits
  localparam int         CTL_RANGE     = 3;
  localparam int         CTL_OCT       = 4;
  localparam int         CTL_ENABLE    = 5;
  localparam int         CTL_CLIM      = 6;
  localparam int         CTL_TONE      = 7;
  localparam int         ST_THERMAL    = 0;
  localparam int         ST_OVERCUR    = 1;
  localparam int         ST_POWER_LOW  = 4;
  localparam int         ST_OUT_OFF    = 5;
  localparam int         ST_UNDERVOLT  = 7;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CTL_RESET     = 8'h00;   // All control off
  localparam logic       OUT_OFF_RESET = 1'b1;    // Output starts disabled
  localparam logic       UV_RESET      = 1'b1;    // Power-up flagged as UV

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int OC_DETECT_NS   = 2000;           // Overcurrent detection time
  localparam int OC_DETECT_CYC  = (OC_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : lnb_regs_pkg

/* File: verilog/pin_sync.sv */
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous levels; only q is read downstream.
module pin_sync #(
  parameter int          WIDTH   = 1,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;  // First stage, read only by q

  // ------------------------------------------------------------------
  // Two stages, constant reset value
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= RST_VAL[WIDTH-1:0];
      q      <= RST_VAL[WIDTH-1:0];
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // pin_sync

/* File: verilog/fault_latch.sv */
// Sticky fault flag with resample at the status-read acknowledge.
// Assumes set and resample are one-cycle pulses on clk.
module fault_latch #(
  parameter logic RST_VAL     = 1'b0,
  parameter logic KEEP_ACTIVE = 1'b1   // Resample keeps flag while cond holds
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic set_evt,
  input  wire logic resample,
  input  wire logic cond,
  output logic      flag
);

  // ------------------------------------------------------------------
  // Set wins; only a read resample may clear
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag <= RST_VAL;
    end else if (set_evt) begin
      flag <= 1'b1;                        // [R6]
    end else if (resample) begin
      flag <= KEEP_ACTIVE & cond;          // [R10] [R12] [R20]
    end
  end

endmodule // fault_latch

/* File: tb/lnb_control_status_regs_assertions.sv */
// Pin-level checks on the regulator control and status register block.
// Assumes it is bound to the top module and fault levels last many clocks.
module lnb_control_status_regs_assertions #(
  parameter int OC_CYCLES = 250
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       irq_oe_n,
  input wire logic       thermal_cond,
  input wire logic       overcur_cond,
  input wire logic       undervolt_cond,
  input wire logic [2:0] level_trim,
  input wire logic       range_select,
  input wire logic       overcurrent_timeout_enable,
  input wire logic       output_enable,
  input wire logic       current_limit_select,
  input wire logic       tone_gate
);
  timeunit 1ns;
  timeprecision 100ps;
  // Sync and edge latency margin
  localparam int OC_LIM = OC_CYCLES + 8;
  wire logic [6:0] ctl = {tone_gate, current_limit_select, overcurrent_timeout_enable,
                          range_select, level_trim};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_therm_off;
    $rose(thermal_cond) |-> ##[1:6] !output_enable;
  endproperty
  a_therm_off: assert property (p_therm_off)
    else $error("output stayed on after overtemperature");
  property p_therm_irq;
    $rose(thermal_cond) |-> ##[1:6] !irq_oe_n;
  endproperty
  a_therm_irq: assert property (p_therm_irq)
    else $error("no interrupt after overtemperature");
  property p_uv_off;
    $rose(undervolt_cond) |-> ##[1:6] !output_enable;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("output stayed on after undervoltage");
  property p_reset_ctl;
    $rose(arst_n) |-> ctl == 7'h00 && !output_enable;
  endproperty
  a_reset_ctl: assert property (p_reset_ctl)
    else $error("control not zero after reset");
  property p_irq_clr;
    $rose(irq_oe_n) |-> !scl_i;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("interrupt released outside an address acknowledge");
  property p_en_rise;
    $rose(output_enable) |-> scl_i && sda_i;
  endproperty
  a_en_rise: assert property (p_en_rise)
    else $error("output enabled away from a stop");
  property p_ctl_scl;
    $changed(ctl) |-> !scl_i;
  endproperty
  a_ctl_scl: assert property (p_ctl_scl)
    else $error("control bits moved outside a data byte end");
  property p_oc_kill;
    $rose(overcur_cond) && overcurrent_timeout_enable && output_enable
      |-> ##[1:OC_LIM] !output_enable;
  endproperty
  a_oc_kill: assert property (p_oc_kill)
    else $error("output stayed on after timed overcurrent");
endmodule // lnb_control_status_regs_assertions

/* File: tb/i2c_master_model.sv */
// Two-wire bus master model for the register block's serial pins.
// Assumes the bench resolves the open-drain data wire with a pull-up.
module i2c_master_model (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_m,  // Own pull: 1 releases the wire
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 8;  // Clocks per half bit, well over four
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hp();
    repeat (HALF) @(posedge clk);
    #1;
  endtask
  task automatic start();
    hp();
    sda_m = 1'b0;
    hp();
    scl = 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(posedge clk);
    #1 sda_m = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_m = 1'b1;
    hp();
  endtask
  // Late data change avoids false start/stop
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(posedge clk);
    #1 sda_m = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(mack, ack);
  endtask
  // One byte per addressed write
  task automatic wr(input logic [6:0] a, input logic [7:0] v, output logic [1:0] ack);
    logic [7:0] q;
    start();
    xfer({a, 1'b0}, 1'b1, q, ack[1]);
    xfer(v, 1'b1, q, ack[0]);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] s, output logic ack);
    logic n;
    start();
    xfer({a, 1'b1}, 1'b1, s[15:8], ack);
    xfer(8'hFF, 1'b0, s[15:8], n);
    xfer(8'hFF, 1'b1, s[7:0], n);
    stop();
  endtask
endmodule // i2c_master_model

/* File: tb/lnb_control_status_regs_tb.sv */
// Self-checking bench for the regulator control and status registers.
// Assumes the master model and the pin checker are compiled first.
module lnb_control_status_regs_tb import lnb_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         OC_CYCLES = 4;  // Short detection count
  localparam logic [1:0] STRAP = 2'h2;
  localparam logic [6:0] DEV = {ADDR_PREFIX, STRAP};
  logic clk = 1'b0, arst_n = 1'b0, scl, sda_m, sda_w, sda_o, sda_oe_n, irq_o, irq_oe_n;
  logic thermal_cond = 1'b0, overcur_cond = 1'b0, undervolt_cond = 1'b0;
  logic below_85_cond = 1'b0, within_90_cond = 1'b1;
  logic [2:0] level_trim;
  logic range_select, overcurrent_timeout_enable, output_enable;
  logic current_limit_select, tone_gate;
  int   n_fail = 0, samples_checked = 0, cycles = 0;
  assign sda_w = sda_m & (sda_oe_n | sda_o);  // Open-drain wire, pulled up
  always #4 clk = ~clk;
  lnb_control_status_regs #(.OC_CYCLES(OC_CYCLES)) lnb_control_status_regs_i (
    .clk, .arst_n, .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_n, .irq_o, .irq_oe_n,
    .addr_sel(STRAP), .thermal_cond, .overcur_cond, .undervolt_cond, .below_85_cond,
    .within_90_cond, .level_trim, .range_select, .overcurrent_timeout_enable,
    .output_enable, .current_limit_select, .tone_gate);
  i2c_master_model i2c_master_model_i (.clk, .scl, .sda_m, .sda(sda_w));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, well above the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic read_st(input logic [7:0] exp);
    logic [15:0] s;
    logic a;
    i2c_master_model_i.rd(DEV, s, a);
    chk("rd_ack", 8'(a), 8'h00);
    chk("status", s[15:8], exp);
    chk("status2", s[7:0], exp & {undervolt_cond, 5'h1F, 1'b0, thermal_cond});
  endtask
  task automatic write_ctl(input logic [7:0] v);
    logic [1:0] a;
    i2c_master_model_i.wr(DEV, v, a);
    chk("wr_ack", 8'(a), 8'h00);
    wait_clk(2);
  endtask
  // Enable in bit 5, as written
  task automatic ctl_is(input logic [7:0] exp);
    chk("control", {tone_gate, current_limit_select, output_enable,
                    overcurrent_timeout_enable, range_select, level_trim}, exp);
  endtask
  task automatic t_power_up();
    chk("irq_n", 8'({irq_o, irq_oe_n}), 8'h00);
    ctl_is(8'h00);
    read_st(8'hA0);
    chk("irq_n", 8'(irq_oe_n), 8'h01);
    read_st(8'h20);
  endtask
  task automatic t_write();
    logic [1:0] a;
    i2c_master_model_i.wr({ADDR_PREFIX, ~STRAP}, 8'h20, a);
    chk("foreign_ack", 8'(a), 8'h03);
    ctl_is(8'h00);
    write_ctl(8'hF9);
    ctl_is(8'hF9);
    read_st(8'h00);
    write_ctl(8'h5A);
    ctl_is(8'h5A);
    read_st(8'h20);
    chk("irq_n", 8'(irq_oe_n), 8'h01);
  endtask
  task automatic t_thermal();
    write_ctl(8'h20);
    thermal_cond = 1'b1;
    wait_clk(10);
    ctl_is(8'h00);
    chk("irq_n", 8'(irq_oe_n), 8'h00);
    read_st(8'h21);
    read_st(8'h21);
    thermal_cond = 1'b0;
    wait_clk(20);
    read_st(8'h21);
    read_st(8'h20);
    ctl_is(8'h00);
    write_ctl(8'h20);
    ctl_is(8'h20);
  endtask
  task automatic t_overcur();
    write_ctl(8'h30);
    overcur_cond = 1'b1;
    wait_clk(20);
    chk("out_en", 8'(output_enable), 8'h00);
    overcur_cond = 1'b0;
    read_st(8'h22);
    read_st(8'h20);
    write_ctl(8'h20);
    overcur_cond = 1'b1;
    wait_clk(20);
    read_st(8'h00);
    overcur_cond = 1'b0;
  endtask
  task automatic t_undervolt();
    undervolt_cond = 1'b1;
    wait_clk(10);
    chk("out_en", 8'(output_enable), 8'h00);
    undervolt_cond = 1'b0;
    read_st(8'hA0);
    read_st(8'h20);
    write_ctl(8'h20);
  endtask
  task automatic t_power_low();
    below_85_cond = 1'b1;
    within_90_cond = 1'b0;
    wait_clk(10);
    read_st(8'h10);
    below_85_cond = 1'b0;
    within_90_cond = 1'b1;
    wait_clk(10);
    read_st(8'h00);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    wait_clk(3);
    t_power_up();
    t_write();
    t_thermal();
    t_overcur();
    t_undervolt();
    t_power_low();
    finish_test();
  end
endmodule // lnb_control_status_regs_tb
bind lnb_control_status_regs lnb_control_status_regs_assertions #(.OC_CYCLES(OC_CYCLES))
  lnb_control_status_regs_assertions_i (.clk, .arst_n, .scl_i, .sda_i, .irq_oe_n,
  .thermal_cond, .overcur_cond, .undervolt_cond, .level_trim, .range_select,
  .overcurrent_timeout_enable, .output_enable, .current_limit_select, .tone_gate);
